/* File: src/phy_mode_ctrl.sv */
// Operating-mode, sleep and wake controller of a single-pair Ethernet PHY
`timescale 1ns/1ps
`default_nettype none
module phy_mode_ctrl #(
   parameter phy_mode_pkg::tcount_t ACK_CYCLES = phy_mode_pkg::ACK_CYC,
   parameter phy_mode_pkg::tcount_t REQ_CYCLES = phy_mode_pkg::REQ_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic por_ok_i,
   input wire logic standby_supply_rail_i,
   input wire logic role_strap_pin_i,
   input wire logic autonomous_strap_i,
   input wire logic link_up_i,
   input wire logic lps_rx_i,
   input wire logic line_silent_i,
   input wire logic energy_det_i,
   input wire logic wake_rx_i,
   input wire logic sleep_en_i,
   input wire logic tc10_en_i,
   input wire logic sleep_abort_i,
   input wire logic sleep_cmd_i,
   input wire logic standby_exit_i,
   input wire logic wake_pin_i,
   input wire logic mgmt_we_i,
   input wire logic mgmt_re_i,
   input wire logic [15:0] mgmt_addr_i,
   input wire logic [15:0] mgmt_wdata_i,
   output logic [15:0] mgmt_rdata_o,
   output var phy_mode_pkg::mode_t mode_o,
   output logic pcs_pma_en_o,
   output logic termination_o,
   output logic lps_tx_o,
   output logic io_hiz_o,
   output logic regulator_inhibit_out_o,
   output logic master_role_o,
   output logic wake_pin_o,
   output logic wake_pin_oe_n_o
);
   import phy_mode_pkg::*;

   // ****************************************
   // Timers
   // ****************************************
   tmr_if mode_t_if (); // Sleep-ack window and sleep-request timeout
   tmr_if fwd_t_if (); // Wake forwarding pulse

   mode_timer u_mode_tmr (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .t(mode_t_if.tmr)
   );

   mode_timer u_fwd_tmr (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .t(fwd_t_if.tmr)
   );

   // ****************************************
   // State
   // ****************************************
   mode_t state_q, state_d; // Current operating mode
   logic auto_q, auto_d; // Autonomous enable bit
   logic master_q, master_d; // Master role bit
   logic [15:0] rdata_q, rdata_d; // Registered read data
   logic pcs_q, pcs_d; // PCS and PMA enabled
   logic term_q, term_d; // Line termination present
   logic lps_q, lps_d; // LPS code-groups being sent
   logic hiz_q, hiz_d; // All digital pins released
   logic inh_q, inh_d; // Regulator inhibit level
   logic drive_q, drive_d; // Wake pin driven high
   logic oe_n_q, oe_n_d; // Wake pin enable, its own flop, no output gate
   tcount_t mload; // Mode timer load value
   logic mstart; // Mode timer start
   logic fstart; // Forward timer start
   logic mgmt_ok; // Management port is alive
   logic sw_rst; // Hardware reset requested by software
   logic wake_now; // Wake condition while asleep

   // Management is dead while unpowered, in reset and asleep
   assign mgmt_ok = (state_q != ST_POWER_DOWN) && (state_q != ST_RESET) &&
      (state_q != ST_SLEEP);
   assign sw_rst = mgmt_ok && mgmt_we_i && (mgmt_addr_i == REG_BASIC_RESET)
      && mgmt_wdata_i[HW_RESET_BIT];
   // Our own forwarded pulse must not look like a local wake
   assign wake_now = energy_det_i || (wake_pin_i && !drive_q);

   // ****************************************
   // Mode sequencing and registers
   // ****************************************
   always_comb begin
      state_d = state_q;
      auto_d = auto_q;
      master_d = master_q;
      mstart = 1'b0;
      mload = TMR_IDLE;
      // Supply loss overrides everything
      if (!por_ok_i) begin
         state_d = ST_POWER_DOWN;
      end else if (sw_rst) begin
         state_d = ST_RESET;
      end else begin
         unique case (state_q)
            // Supply came good: run the reset step
            ST_POWER_DOWN: begin
               state_d = ST_RESET;
            end
            // Clear and re-sample straps, then pick the start mode
            ST_RESET: begin
               auto_d = RST_AUTO_EN;
               master_d = role_strap_pin_i;
               if (autonomous_strap_i) begin
                  state_d = ST_NORMAL;
               end else if (role_strap_pin_i && standby_supply_rail_i) begin
                  state_d = ST_STANDBY;
               end else begin
                  state_d = ST_NORMAL;
               end
            end
            // Wait for a host command or the autonomous bit
            ST_STANDBY: begin
               if (standby_exit_i || auto_q) begin
                  state_d = ST_NORMAL;
               end
            end
            // Remote request has priority over a local one
            ST_NORMAL: begin
               if (lps_rx_i && tc10_en_i) begin
                  state_d = ST_SLEEP_ACK;
                  mstart = 1'b1;
                  mload = ACK_CYCLES;
               end else if (sleep_cmd_i && tc10_en_i) begin
                  state_d = ST_SLEEP_REQ;
                  mstart = 1'b1;
                  mload = REQ_CYCLES;
               end
            end
            // MAC may abort; silence until the window ends means accept
            ST_SLEEP_ACK: begin
               if (!tc10_en_i || sleep_abort_i) begin
                  state_d = ST_NORMAL;
                  mstart = 1'b1;
               end else if (mode_t_if.expired) begin
                  state_d = ST_SLEEP_REQ;
                  mstart = 1'b1;
                  mload = REQ_CYCLES;
               end
            end
            // LPS from the partner arriving with the timeout still wins
            ST_SLEEP_REQ: begin
               if (lps_rx_i) begin
                  state_d = ST_SLEEP_SILENT;
               end else if (mode_t_if.expired) begin
                  state_d = ST_SLEEP_FAIL;
               end
            end
            // Timer keeps running from sleep request
            ST_SLEEP_SILENT: begin
               if (mode_t_if.expired) begin
                  state_d = ST_SLEEP_FAIL;
               end else if (line_silent_i) begin
                  mstart = 1'b1;
                  state_d = sleep_en_i ? ST_SLEEP : ST_STANDBY;
               end
            end
            // One cycle of failure, then back to work
            ST_SLEEP_FAIL: begin
               state_d = ST_NORMAL;
            end
            // Waking reruns reset since nothing was kept
            ST_SLEEP: begin
               auto_d = RST_AUTO_EN;
               master_d = RST_MASTER;
               if (wake_now) begin
                  state_d = ST_RESET;
               end
            end
         endcase
         // Register writes, only while management is alive
         if (mgmt_ok && mgmt_we_i) begin
            if (mgmt_addr_i == REG_AUTO_MODE) begin
               auto_d = mgmt_wdata_i[AUTO_EN_BIT];
            end
            if (mgmt_addr_i == REG_PMA_ROLE) begin
               master_d = mgmt_wdata_i[MASTER_BIT];
            end
         end
      end
      // Link up clears the bit even against a write, a reset or power loss
      if (link_up_i && state_q != ST_RESET) begin
         auto_d = 1'b0;
      end
   end

   // ****************************************
   // Outputs, read data and wake forwarding
   // ****************************************
   always_comb begin
      pcs_d = (state_d == ST_NORMAL) || (state_d == ST_SLEEP_ACK) ||
         (state_d == ST_SLEEP_REQ) || (state_d == ST_SLEEP_SILENT) ||
         (state_d == ST_SLEEP_FAIL);
      term_d = pcs_d;
      lps_d = (state_d == ST_SLEEP_REQ);
      hiz_d = (state_d == ST_POWER_DOWN);
      inh_d = pcs_d || (state_d == ST_STANDBY);
      // Forwarding starts only when idle, so one pulse per event burst
      fstart = por_ok_i && wake_rx_i && !fwd_t_if.busy;
      drive_d = fwd_t_if.busy && por_ok_i;
      oe_n_d = !drive_d;
      rdata_d = rdata_q;
      if (mgmt_re_i) begin
         rdata_d = RDATA_NONE;
         if (mgmt_ok && mgmt_addr_i == REG_AUTO_MODE) begin
            rdata_d[AUTO_EN_BIT] = auto_q;
         end
         if (mgmt_ok && mgmt_addr_i == REG_PMA_ROLE) begin
            rdata_d[MASTER_BIT] = master_q;
         end
      end
   end

   assign mode_t_if.start = mstart;
   assign mode_t_if.load = mload;
   assign fwd_t_if.start = fstart;
   assign fwd_t_if.load = WAKE_CYC;

   // Register stage for all state and outputs
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_RESET;
         auto_q <= RST_AUTO_EN;
         master_q <= RST_MASTER;
         rdata_q <= RDATA_NONE;
         pcs_q <= 1'b0;
         term_q <= 1'b0;
         lps_q <= 1'b0;
         hiz_q <= 1'b0;
         inh_q <= 1'b0;
         drive_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         state_q <= state_d;
         auto_q <= auto_d;
         master_q <= master_d;
         rdata_q <= rdata_d;
         pcs_q <= pcs_d;
         term_q <= term_d;
         lps_q <= lps_d;
         hiz_q <= hiz_d;
         inh_q <= inh_d;
         drive_q <= drive_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign mgmt_rdata_o = rdata_q;
   assign mode_o = state_q;
   assign pcs_pma_en_o = pcs_q;
   assign termination_o = term_q;
   assign lps_tx_o = lps_q;
   assign io_hiz_o = hiz_q;
   assign regulator_inhibit_out_o = inh_q;
   assign master_role_o = master_q;
   assign wake_pin_o = drive_q;
   assign wake_pin_oe_n_o = oe_n_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   chk_pd_release: assert property (
      !por_ok_i |=> io_hiz_o && !termination_o && !pcs_pma_en_o)
      else $error("power-down did not release pins");
   chk_sw_reset: assert property (
      por_ok_i && sw_rst |=> mode_o == ST_RESET && !regulator_inhibit_out_o)
      else $error("software reset not taken");
   chk_strap_load: assert property (
      por_ok_i && mode_o == ST_RESET && !(mgmt_we_i && mgmt_ok)
      |=> master_role_o == $past(role_strap_pin_i))
      else $error("role strap not loaded");
   chk_standby_entry: assert property (
      por_ok_i && mode_o == ST_RESET && !autonomous_strap_i &&
      role_strap_pin_i && standby_supply_rail_i
      |=> mode_o == ST_STANDBY && !termination_o)
      else $error("standby not entered after reset");
   chk_auto_normal: assert property (
      por_ok_i && mode_o == ST_RESET && autonomous_strap_i
      |=> mode_o == ST_NORMAL && pcs_pma_en_o)
      else $error("autonomous strap not honoured");
   chk_auto_clear: assert property (
      link_up_i && mode_o != ST_RESET |=> !auto_q)
      else $error("autonomous bit not cleared");
   chk_req_timeout: assert property (
      por_ok_i && !sw_rst && mode_o == ST_SLEEP_REQ && !lps_rx_i &&
      mode_t_if.expired |=> mode_o == ST_SLEEP_FAIL ##1 mode_o == ST_NORMAL)
      else $error("sleep request timeout not handled");
   chk_req_lps: assert property (
      $rose(lps_tx_o) |-> mode_o == ST_SLEEP_REQ && mode_t_if.busy)
      else $error("LPS sent without timeout running");
   chk_wake_pulse: assert property (
      por_ok_i && wake_rx_i && !fwd_t_if.busy ##1 por_ok_i[*2]
      |-> wake_pin_o && !wake_pin_oe_n_o)
      else $error("wake not forwarded");
   chk_sleep_wake: assert property (
      por_ok_i && !sw_rst && mode_o == ST_SLEEP && energy_det_i
      |=> mode_o == ST_RESET)
      else $error("line energy did not wake");
   chk_inh_sleep: assert property (
      mode_o == ST_SLEEP || mode_o == ST_POWER_DOWN
      |-> !regulator_inhibit_out_o)
      else $error("inhibit held while asleep");
endmodule // phy_mode_ctrl
`default_nettype wire

/* File: src/phy_mode_pkg.sv */
// Constants, register map and mode encoding of the PHY operating-mode controller
package phy_mode_pkg;

   // ****************************************
   // Management register map
   // ****************************************
   localparam logic [15:0] REG_BASIC_RESET = 16'h001f; // Basic reset control
   localparam logic [15:0] REG_AUTO_MODE = 16'h018b; // Autonomous mode control
   localparam logic [15:0] REG_PMA_ROLE = 16'h1834; // PMA role control
   localparam int HW_RESET_BIT = 15; // Self-clearing hardware reset
   localparam int AUTO_EN_BIT = 6; // Autonomous enable, cleared on link up
   localparam int MASTER_BIT = 14; // Master role select
   localparam logic [15:0] RDATA_NONE = 16'h0000; // Unmapped or blocked read
   localparam logic RST_AUTO_EN = 1'b0; // Autonomous bit after reset
   localparam logic RST_MASTER = 1'b0; // Role before straps are loaded

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_KHZ = 40000; // 40 MHz system clock
   localparam int ACK_WINDOW_US = 8000; // MAC decision window, 8 ms
   localparam int REQ_TIMEOUT_US = 16000; // Sleep-request timeout, 16 ms
   localparam int WAKE_PULSE_US = 40; // Forwarded wake pulse, 40 us
   localparam int TMR_W = 20; // Wide enough for the 16 ms count

   typedef logic [TMR_W-1:0] tcount_t; // Timer count type

   localparam tcount_t ACK_CYC =
      tcount_t'(ACK_WINDOW_US * (CLK_KHZ / 1000)); // Window in cycles
   localparam tcount_t REQ_CYC =
      tcount_t'(REQ_TIMEOUT_US * (CLK_KHZ / 1000)); // Timeout in cycles
   localparam tcount_t WAKE_CYC =
      tcount_t'(WAKE_PULSE_US * (CLK_KHZ / 1000)); // Pulse in cycles
   localparam tcount_t TMR_IDLE = '0; // Loading zero cancels a timer

   // ****************************************
   // Operating modes
   // ****************************************
   typedef enum logic [3:0] {
      ST_POWER_DOWN,
      ST_RESET,
      ST_STANDBY,
      ST_NORMAL,
      ST_SLEEP_ACK,
      ST_SLEEP_REQ,
      ST_SLEEP_SILENT,
      ST_SLEEP_FAIL,
      ST_SLEEP
   } mode_t;

endpackage

/* File: src/tmr_if.sv */
// Start, load and status signals between the mode controller and a timer
`timescale 1ns/1ps
`default_nettype none
interface tmr_if;
   import phy_mode_pkg::*;
   tcount_t load; // Cycles to run, zero cancels
   logic start; // One-cycle load strobe
   logic busy; // Count still running
   logic expired; // One-cycle pulse after the last counted cycle
   modport ctrl (output load, output start, input busy, input expired);
   modport tmr (input load, input start, output busy, output expired);
endinterface
`default_nettype wire

/* File: src/mode_timer.sv */
// Down-counting one-shot timer used for sleep windows and wake pulses
`timescale 1ns/1ps
`default_nettype none
module mode_timer (
   input wire logic clk_i,
   input wire logic nrst_i,
   tmr_if.tmr t
);
   import phy_mode_pkg::*;

   // ****************************************
   // Counter
   // ****************************************
   tcount_t cnt_q; // Remaining cycles
   tcount_t cnt_d;
   logic exp_q; // Registered expiry pulse
   logic exp_d;

   // Next count: a start always reloads, so a restart never merges
   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (t.start) begin
         cnt_d = t.load;
      end else if (cnt_q != TMR_IDLE) begin
         cnt_d = cnt_q - tcount_t'(1);
         exp_d = (cnt_q == tcount_t'(1));
      end
   end

   // Register stage
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= TMR_IDLE;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign t.busy = (cnt_q != TMR_IDLE);
   assign t.expired = exp_q;
endmodule // mode_timer
`default_nettype wire

/* File: verification/link_partner_model.sv */
// Behavioural link partner on the far side of the single-pair line
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic lps_tx_i, // Device is sending LPS
   input wire logic agree_i, // Partner accepts a sleep request
   input wire logic slow_i, // Partner answers late
   input wire logic req_i, // Partner asks for sleep itself
   input wire logic wake_i, // Partner sends wake-up pulses
   output logic lps_rx_o,
   output logic line_silent_o,
   output logic energy_det_o,
   output logic wake_rx_o
);
   // ****************************************
   // Sleep handshake
   // ****************************************
   logic [3:0] cnt_q; // Cycles of device LPS heard so far
   logic [3:0] cnt_d;
   logic reply_q; // Partner has agreed and answers with LPS
   logic reply_d;
   // Answer only after hearing LPS for a while, prompt or slow
   always_comb begin
      cnt_d = lps_tx_i ? cnt_q + 4'h1 : 4'h0;
      reply_d = agree_i & (reply_q | (cnt_q == (slow_i ? 4'hc : 4'h3)));
   end
   // Registers of the handshake
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= 4'h0;
         reply_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         reply_q <= reply_d;
      end
   end
   // Own LPS on request, else only while the device still sends; a refusal never answers
   assign lps_rx_o = req_i | (reply_q & lps_tx_i);
   // Partner falls quiet once the device has stopped its LPS
   assign line_silent_o = reply_q & ~lps_tx_i;
   assign energy_det_o = wake_i;
   assign wake_rx_o = wake_i;
endmodule // link_partner_model
`default_nettype wire

/* File: verification/phy_mode_ctrl_tb_top.sv */
// Self-checking testbench of the PHY operating-mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
   end \
end
module phy_mode_ctrl_tb_top;
   import phy_mode_pkg::*;
   // ****************************************
   // Stimulus and wiring
   // ****************************************
   localparam tcount_t ACK_C = 20; // Short decision window keeps runs brief
   localparam tcount_t REQ_C = 40; // Short sleep-request timeout
   localparam int P_CMD = 0; // Strobe indices
   localparam int P_EXIT = 1;
   localparam int P_REQ = 2;
   localparam int P_ABORT = 3;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic por_ok = 1'b1;
   logic rail = 1'b1; // Sleep supply, dropped once around a reset
   logic role_strap = 1'b1; // Master strap, so managed start is standby
   logic auto_strap = 1'b0;
   logic link_up = 1'b0;
   logic sleep_en = 1'b1;
   logic tc10_en = 1'b1;
   logic [3:0] pls = 4'h0; // One-cycle host and partner strobes
   logic we = 1'b0;
   logic re = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wdata = 16'h0000;
   logic agree = 1'b0;
   logic slow = 1'b0;
   logic p_wake = 1'b0;
   logic wake_drv = 1'b0; // Local controller level on the wake pin
   logic lps_rx, silent, energy, wake_rx, lps_tx, pcs, term;
   logic hiz, regulator_inhibit_out, master, wpin_o, wpin_oe_n;
   logic [15:0] rdata;
   mode_t mode;
   wire logic wake_wire; // Resolved wake pin: device wins while driving
   int error_cnt = 0;
   int checks_done = 0;
   assign wake_wire = wpin_oe_n ? wake_drv : wpin_o;
   always #12.5 clk_i = ~clk_i;
   phy_mode_ctrl #(.ACK_CYCLES(ACK_C), .REQ_CYCLES(REQ_C)) phy_mode_ctrl_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .por_ok_i(por_ok),
      .standby_supply_rail_i(rail), .role_strap_pin_i(role_strap),
      .autonomous_strap_i(auto_strap), .link_up_i(link_up),
      .lps_rx_i(lps_rx), .line_silent_i(silent), .energy_det_i(energy),
      .wake_rx_i(wake_rx), .sleep_en_i(sleep_en), .tc10_en_i(tc10_en),
      .sleep_abort_i(pls[P_ABORT]), .sleep_cmd_i(pls[P_CMD]),
      .standby_exit_i(pls[P_EXIT]), .wake_pin_i(wake_wire),
      .mgmt_we_i(we), .mgmt_re_i(re), .mgmt_addr_i(addr),
      .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .mode_o(mode),
      .pcs_pma_en_o(pcs), .termination_o(term), .lps_tx_o(lps_tx),
      .io_hiz_o(hiz), .regulator_inhibit_out_o(regulator_inhibit_out),
      .master_role_o(master), .wake_pin_o(wpin_o),
      .wake_pin_oe_n_o(wpin_oe_n)
   );
   link_partner_model link_partner_model_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .lps_tx_i(lps_tx), .agree_i(agree),
      .slow_i(slow), .req_i(pls[P_REQ]), .wake_i(p_wake),
      .lps_rx_o(lps_rx), .line_silent_o(silent), .energy_det_o(energy),
      .wake_rx_o(wake_rx)
   );
   // ****************************************
   // Access tasks
   // ****************************************
   task tick(int n = 1);
      repeat (n) @(posedge clk_i);
   endtask
   // Write strobe for one cycle; returns just after the taking edge
   task wr(logic [15:0] a, logic [15:0] d);
      tick();
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      tick();
      we <= 1'b0;
      #1;
   endtask
   // Read data is registered on the strobe edge
   task rd(logic [15:0] a, logic [15:0] exp);
      tick();
      re <= 1'b1;
      addr <= a;
      tick();
      re <= 1'b0;
      #1;
      `CHK("rdata", exp, rdata)
   endtask
   // One-cycle strobe; the mode reacts at the edge that samples it
   task pulse(int w);
      tick();
      pls[w] <= 1'b1;
      tick();
      pls[w] <= 1'b0;
      #1;
   endtask
   // Bounded wait for a mode
   task wm(mode_t m, int n);
      int i;
      i = 0;
      while (mode !== m && i < n) begin
         tick();
         #1;
         i++;
      end
      `CHK("mode", m, mode)
   endtask
   task done(string s);
      $display("test %s done, %0d errors", s, error_cnt);
   endtask
   task end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog: the sequence needs about 3400 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      end_of_test();
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      tick(20);
      nrst_i <= 1'b1;
      wm(ST_STANDBY, 5);
      `CHK("pcs_pma", 1'b0, pcs)
      `CHK("term", 1'b0, term)
      `CHK("inhibit", 1'b1, regulator_inhibit_out)
      `CHK("master", 1'b1, master)
      rd(REG_PMA_ROLE, 16'h4000);
      rd(REG_AUTO_MODE, 16'h0000);
      rd(16'h0042, RDATA_NONE);
      pulse(P_EXIT);
      `CHK("mode", ST_NORMAL, mode)
      `CHK("pcs_term", 2'b11, {pcs, term})
      wr(REG_AUTO_MODE, 16'h0040);
      rd(REG_AUTO_MODE, 16'h0040);
      tick();
      link_up <= 1'b1;
      rd(REG_AUTO_MODE, 16'h0000);
      rd(REG_BASIC_RESET, 16'h0000);
      done("registers");
      // Forwarded wake: high two edges after the request, 1600 cycles long
      tick();
      p_wake <= 1'b1;
      tick();
      p_wake <= 1'b0;
      tick(1);
      #1;
      `CHK("wake_out", 2'b10, {wpin_o, wpin_oe_n})
      tick(1599);
      #1;
      `CHK("wake_out", 2'b10, {wpin_o, wpin_oe_n})
      tick();
      #1;
      `CHK("wake_out", 2'b01, {wpin_o, wpin_oe_n})
      done("wake forward");
      // Partner sleep request, aborted by pin and by feature disable
      pulse(P_REQ);
      `CHK("mode", ST_SLEEP_ACK, mode)
      pulse(P_ABORT);
      `CHK("mode", ST_NORMAL, mode)
      pulse(P_REQ);
      tick();
      tc10_en <= 1'b0;
      tick();
      tc10_en <= 1'b1;
      #1;
      `CHK("mode", ST_NORMAL, mode)
      // Accepted by silence, partner never answers: timeout fails
      pulse(P_REQ);
      tick(ACK_C - 2);
      #1;
      `CHK("mode", ST_SLEEP_ACK, mode)
      wm(ST_SLEEP_REQ, 5);
      `CHK("lps_tx", 1'b1, lps_tx)
      tick(REQ_C - 5);
      #1;
      `CHK("mode", ST_SLEEP_REQ, mode)
      wm(ST_SLEEP_FAIL, 10);
      wm(ST_NORMAL, 3);
      done("sleep ack");
      // Local sleep with sleep disabled ends in standby
      tick();
      sleep_en <= 1'b0;
      agree <= 1'b1;
      slow <= 1'b1;
      pulse(P_CMD);
      `CHK("mode", ST_SLEEP_REQ, mode)
      wm(ST_SLEEP_SILENT, 20);
      `CHK("lps_tx", 1'b0, lps_tx)
      wm(ST_STANDBY, 5);
      tick();
      agree <= 1'b0;
      slow <= 1'b0;
      pulse(P_EXIT);
      // Local sleep into sleep, then local wake; register contents lost
      wr(REG_PMA_ROLE, 16'h0000);
      `CHK("master", 1'b0, master)
      tick();
      sleep_en <= 1'b1;
      agree <= 1'b1;
      pulse(P_CMD);
      wm(ST_SLEEP, 20);
      `CHK("inhibit", 1'b0, regulator_inhibit_out)
      `CHK("pcs_term", 2'b00, {pcs, term})
      rd(REG_PMA_ROLE, RDATA_NONE);
      tick(10);
      #1;
      `CHK("mode", ST_SLEEP, mode)
      tick();
      agree <= 1'b0;
      wake_drv <= 1'b1;
      wm(ST_RESET, 3);
      wm(ST_STANDBY, 3);
      `CHK("inhibit", 1'b1, regulator_inhibit_out)
      `CHK("master", 1'b1, master)
      tick(1600);
      wake_drv <= 1'b0;
      // Sleep again, woken by line energy
      pulse(P_EXIT);
      tick();
      agree <= 1'b1;
      pulse(P_CMD);
      wm(ST_SLEEP, 20);
      tick();
      agree <= 1'b0;
      p_wake <= 1'b1;
      wm(ST_RESET, 3);
      tick();
      p_wake <= 1'b0;
      wm(ST_STANDBY, 3);
      done("sleep wake");
      // Autonomous bit set in standby leaves it; link up clears it again
      tick();
      link_up <= 1'b0;
      wr(REG_AUTO_MODE, 16'h0040);
      wm(ST_NORMAL, 3);
      tick();
      link_up <= 1'b1;
      rd(REG_AUTO_MODE, 16'h0000);
      // Software reset, supply loss, autonomous slave strap
      wr(REG_BASIC_RESET, 16'h8000);
      `CHK("mode", ST_RESET, mode)
      wm(ST_STANDBY, 3);
      tick();
      por_ok <= 1'b0;
      tick();
      #1;
      `CHK("mode", ST_POWER_DOWN, mode)
      `CHK("pins", 3'b100, {hiz, term, regulator_inhibit_out})
      tick();
      por_ok <= 1'b1;
      wm(ST_STANDBY, 4);
      // Without the sleep supply a managed master starts in normal
      tick();
      rail <= 1'b0;
      wr(REG_BASIC_RESET, 16'h8000);
      wm(ST_NORMAL, 3);
      tick();
      rail <= 1'b1;
      tick();
      role_strap <= 1'b0;
      auto_strap <= 1'b1;
      nrst_i <= 1'b0;
      tick(2);
      nrst_i <= 1'b1;
      wm(ST_NORMAL, 4);
      `CHK("master", 1'b0, master)
      done("resets");
      end_of_test();
   end
endmodule // phy_mode_ctrl_tb_top
`default_nettype wire
